// file: hdl/fan_thermal_regs.sv
// Host register bank of the temperature monitor and fan controller
`timescale 1ns/1ps

module fan_thermal_regs #(
  parameter logic [7:0] PART_ID  = 8'hA5,  // Arbitrary value
  parameter logic [7:0] MAKER_ID = 8'h5A,  // Arbitrary value
  parameter logic [3:0] REVISION = 4'h1,   // Arbitrary value
  parameter int unsigned ADDR_W  = fan_thermal_pkg::ADDR_W
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  input  wire fan_thermal_pkg::host_req_t req,
  input  wire fan_thermal_pkg::meas_t     meas,
  output logic [7:0]                     rd_data_q,
  output logic                           rd_valid_q,
  output fan_thermal_pkg::cfg_out_t      cfg_q,
  output logic                           fan_slow_q,
  output logic                           restart_q
);

  if (ADDR_W != 8) begin : g_addr_check
    $error("Register address must be eight bits wide");
  end

  localparam int unsigned DEPTH = fan_thermal_pkg::MAP_DEPTH;

  // Power-on value of each stored location
  function automatic logic [7:0] reset_val(input logic [5:0] idx);
    logic [7:0] a;
    a = {2'b00, idx};
    unique case (a)
      fan_thermal_pkg::MAIN_CFG_OFS:    reset_val = fan_thermal_pkg::MAIN_CFG_RST;
      fan_thermal_pkg::SECOND_CFG_OFS:  reset_val = fan_thermal_pkg::SECOND_CFG_RST;
      fan_thermal_pkg::FAN_LIMIT_OFS:   reset_val = fan_thermal_pkg::FAN_LIMIT_RST;
      fan_thermal_pkg::LOCAL_HIGH_OFS:  reset_val = fan_thermal_pkg::LOCAL_HIGH_RST;
      fan_thermal_pkg::LOCAL_LOW_OFS:   reset_val = fan_thermal_pkg::LOCAL_LOW_RST;
      fan_thermal_pkg::LOCAL_OVER_OFS:  reset_val = fan_thermal_pkg::LOCAL_OVER_RST;
      fan_thermal_pkg::REMOTE_HIGH_OFS: reset_val = fan_thermal_pkg::REMOTE_HIGH_RST;
      fan_thermal_pkg::REMOTE_LOW_OFS:  reset_val = fan_thermal_pkg::REMOTE_LOW_RST;
      fan_thermal_pkg::REMOTE_OVER_OFS: reset_val = fan_thermal_pkg::REMOTE_OVER_RST;
      fan_thermal_pkg::FAN_CHAR_OFS:    reset_val = fan_thermal_pkg::FAN_CHAR_RST;
      fan_thermal_pkg::FAN_SPEED_OFS:   reset_val = fan_thermal_pkg::FAN_SPEED_RST;
      fan_thermal_pkg::FAN_FILTER_OFS:  reset_val = fan_thermal_pkg::FAN_FILTER_RST;
      fan_thermal_pkg::LOCAL_SPAN_OFS:  reset_val = fan_thermal_pkg::LOCAL_SPAN_RST;
      fan_thermal_pkg::REMOTE_SPAN_OFS: reset_val = fan_thermal_pkg::REMOTE_SPAN_RST;
      default:                          reset_val = fan_thermal_pkg::PLAIN_RST;
    endcase
  endfunction : reset_val

  // Host-writable locations; everything else drops writes
  function automatic logic is_rw(input logic [7:0] a);
    unique case (a)
      fan_thermal_pkg::MAIN_CFG_OFS,    fan_thermal_pkg::SECOND_CFG_OFS,
      fan_thermal_pkg::FAN_COUNT_OFS,   fan_thermal_pkg::LOCAL_OFFSET_OFS,
      fan_thermal_pkg::REMOTE_OFFSET_OFS, fan_thermal_pkg::FAN_LIMIT_OFS,
      fan_thermal_pkg::LOCAL_HIGH_OFS,  fan_thermal_pkg::LOCAL_LOW_OFS,
      fan_thermal_pkg::LOCAL_OVER_OFS,  fan_thermal_pkg::REMOTE_HIGH_OFS,
      fan_thermal_pkg::REMOTE_LOW_OFS,  fan_thermal_pkg::REMOTE_OVER_OFS,
      fan_thermal_pkg::FAN_CHAR_OFS,    fan_thermal_pkg::FAN_SPEED_OFS,
      fan_thermal_pkg::FAN_FILTER_OFS,  fan_thermal_pkg::LOCAL_SPAN_OFS,
      fan_thermal_pkg::REMOTE_SPAN_OFS, fan_thermal_pkg::REVISION_OFS:
        is_rw = 1'b1;
      default:
        is_rw = 1'b0;
    endcase
  endfunction : is_rw

  logic [7:0] regs_q [0:DEPTH-1];
  logic [7:0] primary_stat_q;
  logic [7:0] second_stat_q;
  logic [7:0] rd_mux;

  wire        in_map      = (req.addr[7:6] == 2'b00);
  wire        wr_go       = ce && req.wr && in_map && is_rw(req.addr);
  wire        rd_go       = ce && req.rd;
  wire        restart_req = ce && req.wr && (req.addr == fan_thermal_pkg::SECOND_CFG_OFS)
                            && req.data[fan_thermal_pkg::RESTART_BIT];
  wire [7:0]  tach_sat    = req_sat(meas.tach_raw);
  wire [7:0]  fan_count   = regs_q[fan_thermal_pkg::FAN_COUNT_OFS[5:0]];
  wire [7:0]  fan_limit   = regs_q[fan_thermal_pkg::FAN_LIMIT_OFS[5:0]];
  wire        fan_fail    = meas.tach_valid && (tach_sat > fan_limit);
  wire        rd_primary  = rd_go && (req.addr == fan_thermal_pkg::PRIMARY_STAT_OFS);
  wire        rd_second   = rd_go && (req.addr == fan_thermal_pkg::SECOND_STAT_OFS);
  wire [7:0]  fail_vec    = 8'(fan_fail) << fan_thermal_pkg::FAN_FAULT_BIT;
  wire [7:0]  primary_new = meas.primary_set | fail_vec;

  // A count beyond eight bits means a stalled fan
  function automatic logic [7:0] req_sat(input logic [8:0] raw);
    req_sat = raw[8] ? fan_thermal_pkg::FAN_COUNT_MAX : raw[7:0];
  endfunction : req_sat

  // Byte stored on a host write; the restart bit is never kept
  function automatic logic [7:0] wr_val(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == fan_thermal_pkg::SECOND_CFG_OFS)
      v[fan_thermal_pkg::RESTART_BIT] = 1'b0;
    if (a == fan_thermal_pkg::REVISION_OFS)
      v = d & (8'h01 << fan_thermal_pkg::OVERTEMP_FAN_BIT);
    wr_val = v;
  endfunction : wr_val

  always_comb
  begin
    rd_mux = 8'h00;
    if (in_map)
    begin
      unique case (req.addr)
        fan_thermal_pkg::PRIMARY_STAT_OFS: rd_mux = primary_stat_q;
        fan_thermal_pkg::SECOND_STAT_OFS:  rd_mux = second_stat_q;
        fan_thermal_pkg::TEMP_FRAC_OFS:    rd_mux = meas.temp_frac;
        fan_thermal_pkg::FACTORY_TEST_OFS: rd_mux = 8'h00;
        fan_thermal_pkg::LOCAL_TEMP_OFS:   rd_mux = meas.local_temp;
        fan_thermal_pkg::REMOTE_TEMP_OFS:  rd_mux = meas.remote_temp;
        fan_thermal_pkg::PART_ID_OFS:      rd_mux = PART_ID;
        fan_thermal_pkg::MAKER_ID_OFS:     rd_mux = MAKER_ID;
        fan_thermal_pkg::REVISION_OFS:
          rd_mux = regs_q[fan_thermal_pkg::REVISION_OFS[5:0]] | {4'h0, REVISION};
        default:
          rd_mux = is_rw(req.addr) ? regs_q[req.addr[5:0]] : 8'h00;
      endcase
    end
  end

  // Restart has priority; a tach sample beats a host write to the count
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
        regs_q[i] <= reset_val(6'(i));
    end
    else if (ce)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (restart_q)
          regs_q[i] <= reset_val(6'(i));
        else if ((i == int'(fan_thermal_pkg::FAN_COUNT_OFS)) && meas.tach_valid)
          regs_q[i] <= tach_sat;
        else if (wr_go && (req.addr[5:0] == 6'(i)))
          regs_q[i] <= wr_val(req.addr, req.data);
      end
    end
  end

  // Sticky status: a read clears, but a same-cycle event still sets
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      primary_stat_q <= fan_thermal_pkg::STAT_RST;
      second_stat_q  <= fan_thermal_pkg::STAT_RST;
    end
    else if (ce)
    begin
      if (restart_q)
      begin
        primary_stat_q <= fan_thermal_pkg::STAT_RST;
        second_stat_q  <= fan_thermal_pkg::STAT_RST;
      end
      else
      begin
        primary_stat_q <= (rd_primary ? 8'h00 : primary_stat_q) | primary_new;
        second_stat_q  <= (rd_second ? 8'h00 : second_stat_q) | meas.second_set;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
      restart_q  <= 1'b0;
      fan_slow_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid_q <= req.rd;
      if (req.rd)
        rd_data_q <= rd_mux;
      restart_q  <= restart_req && !restart_q;
      fan_slow_q <= (fan_count > fan_limit);
    end
  end

  // Configuration fields presented to the fan and thermal engines
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      cfg_q <= '0;
    else if (ce)
    begin
      cfg_q.main_cfg        <= regs_q[fan_thermal_pkg::MAIN_CFG_OFS[5:0]];
      cfg_q.second_cfg      <= regs_q[fan_thermal_pkg::SECOND_CFG_OFS[5:0]];
      cfg_q.fan_char        <= regs_q[fan_thermal_pkg::FAN_CHAR_OFS[5:0]];
      cfg_q.fan_speed       <= regs_q[fan_thermal_pkg::FAN_SPEED_OFS[5:0]];
      cfg_q.fan_filter      <= regs_q[fan_thermal_pkg::FAN_FILTER_OFS[5:0]];
      cfg_q.local_span      <= regs_q[fan_thermal_pkg::LOCAL_SPAN_OFS[5:0]];
      cfg_q.remote_span     <= regs_q[fan_thermal_pkg::REMOTE_SPAN_OFS[5:0]];
      cfg_q.local_offset    <= regs_q[fan_thermal_pkg::LOCAL_OFFSET_OFS[5:0]];
      cfg_q.remote_offset   <= regs_q[fan_thermal_pkg::REMOTE_OFFSET_OFS[5:0]];
      cfg_q.local_high      <= regs_q[fan_thermal_pkg::LOCAL_HIGH_OFS[5:0]];
      cfg_q.local_low       <= regs_q[fan_thermal_pkg::LOCAL_LOW_OFS[5:0]];
      cfg_q.local_over      <= regs_q[fan_thermal_pkg::LOCAL_OVER_OFS[5:0]];
      cfg_q.remote_high     <= regs_q[fan_thermal_pkg::REMOTE_HIGH_OFS[5:0]];
      cfg_q.remote_low      <= regs_q[fan_thermal_pkg::REMOTE_LOW_OFS[5:0]];
      cfg_q.remote_over     <= regs_q[fan_thermal_pkg::REMOTE_OVER_OFS[5:0]];
      cfg_q.overtemp_fan_en <=
        regs_q[fan_thermal_pkg::REVISION_OFS[5:0]][fan_thermal_pkg::OVERTEMP_FAN_BIT];
    end
  end

  sequence s_restart_req;
    ce && req.wr && (req.addr == fan_thermal_pkg::SECOND_CFG_OFS) && req.data[7] && !restart_q;
  endsequence

  sequence s_reload;
    restart_q && ce ##1 (regs_q[0] == 8'h90) && (regs_q[1] == 8'h7F) && !restart_q;
  endsequence

  property p_part_id;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.rd && (req.addr == 8'h3D) |=> rd_valid_q && (rd_data_q == PART_ID);
  endproperty
  a_part_id: assert property (p_part_id) else $error("Part identifier read wrong");

  property p_maker_id;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.wr && (req.addr == 8'h3E) ##1 ce && req.rd && (req.addr == 8'h3E)
      |=> rd_data_q == MAKER_ID;
  endproperty
  a_maker_id: assert property (p_maker_id) else $error("Maker identifier changed");

  property p_revision;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.rd && (req.addr == 8'h3F)
      |=> (rd_data_q[3:0] == REVISION) && (rd_data_q[6:4] == 3'b000);
  endproperty
  a_revision: assert property (p_revision) else $error("Revision field wrong");

  property p_overtemp_en;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.wr && (req.addr == 8'h3F) && !restart_q ##1 ce
      |=> cfg_q.overtemp_fan_en == $past(req.data[7], 2);
  endproperty
  a_overtemp_en: assert property (p_overtemp_en) else $error("Overtemp enable not kept");

  property p_restart;
    @(posedge clk_sys) disable iff (!rstn)
    s_restart_req ##1 ce |-> s_reload;
  endproperty
  a_restart: assert property (p_restart) else $error("Restart did not reload");

  property p_stat_clear;
    @(posedge clk_sys) disable iff (!rstn)
    ce && rd_primary && (primary_new == 8'h00) && !restart_q |=> primary_stat_q == 8'h00;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("Status not cleared");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!rstn)
    ce && rd_second && (meas.second_set != 8'h00) && !restart_q
      |=> (second_stat_q & $past(meas.second_set)) == $past(meas.second_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Status event lost on read");

  property p_saturate;
    @(posedge clk_sys) disable iff (!rstn)
    ce && meas.tach_valid && meas.tach_raw[8] && !restart_q |=> fan_count == 8'hFF;
  endproperty
  a_saturate: assert property (p_saturate) else $error("Stall count not saturated");

  property p_slow;
    @(posedge clk_sys) disable iff (!rstn)
    ce |=> fan_slow_q == ($past(fan_count) > $past(fan_limit));
  endproperty
  a_slow: assert property (p_slow) else $error("Slow fan flag wrong");

  property p_ro_write;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.wr && ((req.addr == 8'h0A) || (req.addr == 8'h40)) && !restart_q
      && !meas.tach_valid |=> $stable(regs_q[0]) && $stable(fan_count) && $stable(fan_limit);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("Read-only write leaked");

  property p_freeze;
    @(posedge clk_sys) disable iff (!rstn)
    !ce |=> $stable(rd_data_q) && $stable(rd_valid_q) && $stable(restart_q)
      && $stable(fan_slow_q) && $stable(cfg_q) && $stable(primary_stat_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while frozen");

  property p_rd_valid;
    @(posedge clk_sys) disable iff (!rstn)
    ce && !req.rd |=> !rd_valid_q;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("Read valid without read");

  property p_unmapped;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.rd && (req.addr[7:6] != 2'b00) |=> rd_data_q == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");

  property p_restart_bit;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.wr && (req.addr == 8'h01) |=> !regs_q[1][7];
  endproperty
  a_restart_bit: assert property (p_restart_bit) else $error("Restart bit was stored");

  property p_local_temp;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.rd && (req.addr == 8'h0A) |=> rd_data_q == $past(meas.local_temp);
  endproperty
  a_local_temp: assert property (p_local_temp) else $error("Local value read wrong");

  property p_remote_temp;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.rd && (req.addr == 8'h0B) |=> rd_data_q == $past(meas.remote_temp);
  endproperty
  a_remote_temp: assert property (p_remote_temp) else $error("Remote value read wrong");

  property p_frac;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.rd && (req.addr == 8'h06) |=> rd_data_q == $past(meas.temp_frac);
  endproperty
  a_frac: assert property (p_frac) else $error("Fraction bits read wrong");

  property p_fan_write;
    @(posedge clk_sys) disable iff (!rstn)
    ce && req.wr && (req.addr == 8'h08) && !meas.tach_valid && !restart_q
      |=> fan_count == $past(req.data);
  endproperty
  a_fan_write: assert property (p_fan_write) else $error("Fan count write lost");

  property p_tach_wins;
    @(posedge clk_sys) disable iff (!rstn)
    ce && meas.tach_valid && !meas.tach_raw[8] && !restart_q
      |=> fan_count == $past(meas.tach_raw[7:0]);
  endproperty
  a_tach_wins: assert property (p_tach_wins) else $error("Tach sample not stored");

  property p_fault_bit;
    @(posedge clk_sys) disable iff (!rstn)
    ce && meas.tach_valid && meas.tach_raw[8] && (fan_limit != 8'hFF) && !restart_q
      |=> primary_stat_q[1];
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("Fan fault bit not set");

endmodule : fan_thermal_regs

// file: hdl/fan_thermal_pkg.sv
// Register map constants and carrier types for the fan and thermal register bank
package fan_thermal_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MAP_DEPTH = 64;

  localparam logic [7:0] MAIN_CFG_OFS       = 8'h00;
  localparam logic [7:0] SECOND_CFG_OFS     = 8'h01;
  localparam logic [7:0] PRIMARY_STAT_OFS   = 8'h02;
  localparam logic [7:0] SECOND_STAT_OFS    = 8'h03;
  localparam logic [7:0] TEMP_FRAC_OFS      = 8'h06;
  localparam logic [7:0] FACTORY_TEST_OFS   = 8'h07;
  localparam logic [7:0] FAN_COUNT_OFS      = 8'h08;
  localparam logic [7:0] LOCAL_TEMP_OFS     = 8'h0A;
  localparam logic [7:0] REMOTE_TEMP_OFS    = 8'h0B;
  localparam logic [7:0] LOCAL_OFFSET_OFS   = 8'h0D;
  localparam logic [7:0] REMOTE_OFFSET_OFS  = 8'h0E;
  localparam logic [7:0] FAN_LIMIT_OFS      = 8'h10;
  localparam logic [7:0] LOCAL_HIGH_OFS     = 8'h14;
  localparam logic [7:0] LOCAL_LOW_OFS      = 8'h15;
  localparam logic [7:0] LOCAL_OVER_OFS     = 8'h16;
  localparam logic [7:0] REMOTE_HIGH_OFS    = 8'h18;
  localparam logic [7:0] REMOTE_LOW_OFS     = 8'h19;
  localparam logic [7:0] REMOTE_OVER_OFS    = 8'h1A;
  localparam logic [7:0] FAN_CHAR_OFS       = 8'h20;
  localparam logic [7:0] FAN_SPEED_OFS      = 8'h22;
  localparam logic [7:0] FAN_FILTER_OFS     = 8'h23;
  localparam logic [7:0] LOCAL_SPAN_OFS     = 8'h24;
  localparam logic [7:0] REMOTE_SPAN_OFS    = 8'h25;
  localparam logic [7:0] PART_ID_OFS        = 8'h3D;
  localparam logic [7:0] MAKER_ID_OFS       = 8'h3E;
  localparam logic [7:0] REVISION_OFS       = 8'h3F;

  localparam logic [7:0] MAIN_CFG_RST       = 8'h90;
  localparam logic [7:0] SECOND_CFG_RST     = 8'h7F;
  localparam logic [7:0] STAT_RST           = 8'h00;
  localparam logic [7:0] FAN_LIMIT_RST      = 8'hFF;
  localparam logic [7:0] LOCAL_HIGH_RST     = 8'h3C;
  localparam logic [7:0] LOCAL_LOW_RST      = 8'h00;
  localparam logic [7:0] LOCAL_OVER_RST     = 8'h46;
  localparam logic [7:0] REMOTE_HIGH_RST    = 8'h50;
  localparam logic [7:0] REMOTE_LOW_RST     = 8'h00;
  localparam logic [7:0] REMOTE_OVER_RST    = 8'h64;
  localparam logic [7:0] FAN_CHAR_RST       = 8'h5D;
  localparam logic [7:0] FAN_SPEED_RST      = 8'h55;
  localparam logic [7:0] FAN_FILTER_RST     = 8'h55;
  localparam logic [7:0] LOCAL_SPAN_RST     = 8'h41;
  localparam logic [7:0] REMOTE_SPAN_RST    = 8'h61;
  localparam logic [7:0] PLAIN_RST          = 8'h00;

  localparam int unsigned RESTART_BIT       = 7;
  localparam int unsigned OVERTEMP_FAN_BIT  = 7;
  localparam int unsigned FAN_FAULT_BIT     = 1;
  localparam int unsigned REV_W             = 4;
  localparam logic [7:0]  FAN_COUNT_MAX     = 8'hFF;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } host_req_t;

  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote_temp;
    logic [7:0] temp_frac;
    logic       tach_valid;
    logic [8:0] tach_raw;
    logic [7:0] primary_set;
    logic [7:0] second_set;
  } meas_t;

  typedef struct packed {
    logic [7:0] main_cfg;
    logic [7:0] second_cfg;
    logic [7:0] fan_char;
    logic [7:0] fan_speed;
    logic [7:0] fan_filter;
    logic [7:0] local_span;
    logic [7:0] remote_span;
    logic [7:0] local_offset;
    logic [7:0] remote_offset;
    logic [7:0] local_high;
    logic [7:0] local_low;
    logic [7:0] local_over;
    logic [7:0] remote_high;
    logic [7:0] remote_low;
    logic [7:0] remote_over;
    logic       overtemp_fan_en;
  } cfg_out_t;

endpackage : fan_thermal_pkg

// file: sim/fan_thermal_host.sv
// Host and measurement source model facing the register bank
`timescale 1ns/1ps
module fan_thermal_host (
  input  wire logic                  clk_sys,
  input  wire logic [7:0]            rd_data_q,
  input  wire logic                  rd_valid_q,
  output logic                       ce,
  output fan_thermal_pkg::host_req_t req,
  output fan_thermal_pkg::meas_t     meas
);
  initial
  begin
    ce = 1'b1;
    req = '0;
    meas = '0;
  end

  // One request, launched and released on falling edges
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    q = 8'h00;
    v = 1'b1;
    // Factory test location is never touched
    if (a != fan_thermal_pkg::FACTORY_TEST_OFS)
    begin
      @(negedge clk_sys);
      req.rd = !w;
      req.wr = w;
      req.addr = a;
      req.data = d;
      @(negedge clk_sys);
      q = rd_data_q;
      v = rd_valid_q;
      req.rd = 1'b0;
      req.wr = 1'b0;
      // Released lines show a changed value, not the last one
      req.addr = ~a;
      req.data = ~d;
    end
  endtask : access

  task automatic pulse(input logic tv, input logic [8:0] raw, input logic [7:0] ps,
                       input logic [7:0] ss);
    @(negedge clk_sys);
    meas.tach_valid = tv;
    meas.tach_raw = raw;
    meas.primary_set = ps;
    meas.second_set = ss;
    @(negedge clk_sys);
    meas.tach_valid = 1'b0;
    meas.tach_raw = ~raw;
    meas.primary_set = 8'h00;
    meas.second_set = 8'h00;
  endtask : pulse

  // Clock enable moves on a falling edge like every other input
  task automatic hold(input logic e);
    @(negedge clk_sys);
    ce = e;
  endtask : hold

  task automatic temps(input logic [7:0] l, input logic [7:0] r, input logic [7:0] f);
    @(negedge clk_sys);
    meas.local_temp = l;
    meas.remote_temp = r;
    meas.temp_frac = f;
  endtask : temps
endmodule : fan_thermal_host

// file: sim/fan_thermal_regs_test.sv
// Self-checking testbench of the fan and thermal register bank
`timescale 1ns/1ps
module fan_thermal_regs_test;
  localparam logic [7:0] PID = 8'hC3;  // Arbitrary value
  localparam logic [7:0] MID = 8'h96;  // Arbitrary value
  localparam logic [3:0] REV = 4'h6;   // Arbitrary value
  localparam logic [7:0] RA [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h14, 8'h15, 8'h16,
                                    8'h18, 8'h19, 8'h1A, 8'h20, 8'h22, 8'h23, 8'h24, 8'h25};
  localparam logic [7:0] RV [16] = '{8'h90, 8'h7F, 8'h00, 8'h00, 8'hFF, 8'h3C, 8'h00, 8'h46,
                                    8'h50, 8'h00, 8'h64, 8'h5D, 8'h55, 8'h55, 8'h41, 8'h61};
  logic                       clk_sys;
  logic                       rstn;
  logic                       ce;
  fan_thermal_pkg::host_req_t req;
  fan_thermal_pkg::meas_t     meas;
  logic [7:0]                 rd_data_q;
  logic                       rd_valid_q;
  fan_thermal_pkg::cfg_out_t  cfg_q;
  logic                       fan_slow_q;
  logic                       restart_q;
  int                         n_fail = 0;
  int                         n_checks = 0;
  int                         cyc = 0;

  fan_thermal_regs #(.PART_ID(PID), .MAKER_ID(MID), .REVISION(REV)) fan_thermal_regs_i (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .req(req), .meas(meas), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .cfg_q(cfg_q), .fan_slow_q(fan_slow_q), .restart_q(restart_q));
  fan_thermal_host fan_thermal_host_i (
    .clk_sys(clk_sys), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .ce(ce), .req(req),
    .meas(meas));

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic rd(input logic [7:0] a, input logic [7:0] e, output logic [7:0] q);
    logic v;
    fan_thermal_host_i.access(1'b0, a, 8'h00, q, v);
    chk1(v, 1'b1, "read valid");
    chk8(q, e, $sformatf("read %h", a));
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    fan_thermal_host_i.access(1'b1, a, d, q, v);
  endtask : wr

  task automatic test_reset();
    logic [7:0] q;
    chk8(cfg_q.main_cfg, 8'h90, "cfg main");
    chk8(cfg_q.local_over, 8'h46, "cfg local over");
    chk8(cfg_q.remote_over, 8'h64, "cfg remote over");
    chk1(fan_slow_q, 1'b0, "slow at reset");
    for (int i = 0; i < 16; i++)
      rd(RA[i], RV[i], q);
    $display("test reset done");
  endtask : test_reset

  task automatic test_ident();
    logic [7:0] q;
    logic       v;
    wr(8'h3D, ~PID);
    wr(8'h3E, ~MID);
    rd(8'h3D, PID, q);
    rd(8'h3E, MID, q);
    wr(8'h3F, {4'h7, ~REV});
    fan_thermal_host_i.access(1'b0, 8'h3F, 8'h00, q, v);
    chk8({4'h0, q[3:0]}, {4'h0, REV}, "revision");
    chk1(q[7], 1'b0, "overtemp fan off");
    wr(8'h3F, 8'h80);
    fan_thermal_host_i.access(1'b0, 8'h3F, 8'h00, q, v);
    chk1(q[7], 1'b1, "overtemp fan on");
    chk8({4'h0, q[3:0]}, {4'h0, REV}, "revision kept");
    chk1(cfg_q.overtemp_fan_en, 1'b1, "overtemp fan out");
    $display("test ident done");
  endtask : test_ident

  task automatic test_live();
    logic [7:0] q;
    fan_thermal_host_i.temps(8'h2D, 8'h5E, 8'hA0);
    wr(8'h0A, 8'hFF);
    wr(8'h0B, 8'h00);
    wr(8'h06, 8'h11);
    wr(8'h40, 8'h12);
    rd(8'h0A, 8'h2D, q);
    rd(8'h0B, 8'h5E, q);
    rd(8'h06, 8'hA0, q);
    rd(8'h40, 8'h00, q);
    rd(8'hFF, 8'h00, q);
    rd(8'h14, 8'h3C, q);
    $display("test live done");
  endtask : test_live

  task automatic test_rw_restart();
    logic [7:0] q;
    wr(8'h14, 8'hAB);
    wr(8'h1A, 8'h01);
    wr(8'h0D, 8'h7E);
    wr(8'h01, 8'h05);
    rd(8'h14, 8'hAB, q);
    rd(8'h1A, 8'h01, q);
    rd(8'h0D, 8'h7E, q);
    rd(8'h01, 8'h05, q);
    chk8(cfg_q.local_high, 8'hAB, "cfg local high");
    wr(8'h01, 8'h80);
    chk1(restart_q, 1'b1, "restart pulse");
    @(negedge clk_sys);
    chk1(restart_q, 1'b0, "restart ends");
    rd(8'h14, 8'h3C, q);
    rd(8'h01, 8'h7F, q);
    rd(8'h0D, 8'h00, q);
    $display("test rw restart done");
  endtask : test_rw_restart

  task automatic test_fan_status();
    logic [7:0] q;
    logic       v;
    wr(8'h08, 8'h33);
    rd(8'h08, 8'h33, q);
    wr(8'h10, 8'hFE);
    fan_thermal_host_i.pulse(1'b1, 9'h100, 8'h00, 8'h00);
    @(negedge clk_sys);
    chk1(fan_slow_q, 1'b1, "slow when over");
    rd(8'h08, 8'hFF, q);
    rd(8'h02, 8'h02, q);
    rd(8'h02, 8'h00, q);
    fan_thermal_host_i.pulse(1'b1, 9'h0FE, 8'h81, 8'h05);
    @(negedge clk_sys);
    chk1(fan_slow_q, 1'b0, "not slow at limit");
    rd(8'h08, 8'hFE, q);
    rd(8'h02, 8'h81, q);
    rd(8'h03, 8'h05, q);
    rd(8'h03, 8'h00, q);
    fan_thermal_host_i.hold(1'b0);
    fan_thermal_host_i.access(1'b0, 8'h02, 8'h00, q, v);
    chk1(v, 1'b0, "frozen read");
    wr(8'h10, 8'h11);
    fan_thermal_host_i.hold(1'b1);
    rd(8'h10, 8'hFE, q);
    $display("test fan status done");
  endtask : test_fan_status

  initial
  begin
    rstn = 1'b0;
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    test_reset();
    test_ident();
    test_live();
    test_rw_restart();
    test_fan_status();
    results();
  end
endmodule : fan_thermal_regs_test
